// ### design/ftftc_field_cmp.sv
// one field flag comparator with hysteresis
`timescale 1ns/10ps
module ftftc_field_cmp #(
    parameter bit IS_HIGH = 1'b1
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // measurement
    input  wire logic [7:0] field_mt,
    input  wire logic       field_valid,
    // configuration and result
    input  wire logic [2:0] thr_code,
    output logic            flag
);
    import ftftc_pkg::*;

    typedef struct packed {
        logic flag;
    } ftftc_cmp_t;

    ftftc_cmp_t state_ff;
    ftftc_cmp_t nxt_state;
    logic [7:0] trip_mt;
    logic [7:0] release_mt;

    // ------------------------------------------------------------------
    // threshold decode and compare
    // ------------------------------------------------------------------
    always_comb begin
        trip_mt    = FTFTC_TRIP_TABLE[{thr_code, 3'h0} +: 8];
        release_mt = trip_mt - FTFTC_HYST_MT;
        nxt_state  = state_ff;
        if (field_valid) begin
            if (IS_HIGH) begin
                if (field_mt > trip_mt) begin
                    nxt_state.flag = 1'b1;
                end else if (field_mt < release_mt) begin
                    nxt_state.flag = 1'b0;
                end
            end else begin
                if (field_mt < release_mt) begin
                    nxt_state.flag = 1'b1;
                end else if (field_mt > trip_mt) begin
                    nxt_state.flag = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flag = state_ff.flag;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_trip;
        field_valid && (IS_HIGH ? field_mt > trip_mt : field_mt < release_mt)
            |=> flag ##1 (flag || $past(field_valid));
    endproperty
    a_trip: assert property (p_trip) else $error("flag not set past trip");

    property p_hyst;
        flag && field_valid && field_mt >= release_mt && field_mt <= trip_mt
            |=> $stable(flag);
    endproperty
    a_hyst: assert property (p_hyst) else $error("flag moved inside band");

endmodule : ftftc_field_cmp

// ### design/ftftc_pkg.sv
// constants for the field threshold flags and trim configuration block
package ftftc_pkg;

    // ------------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------------
    localparam int          FTFTC_FRAME_BITS = 16;
    localparam int          FTFTC_CMD_MSB    = 15;
    localparam int          FTFTC_CMD_LSB    = 13;
    localparam int          FTFTC_ADDR_MSB   = 12;
    localparam int          FTFTC_ADDR_LSB   = 8;
    localparam logic [4:0]  FTFTC_FRAME_CNT  = 5'h10;
    localparam logic [4:0]  FTFTC_CNT_MAX    = 5'h1f;
    localparam logic [2:0]  FTFTC_CMD_READ   = 3'h2;
    localparam logic [2:0]  FTFTC_CMD_WRITE  = 3'h4;

    // ------------------------------------------------------------------
    // register offsets and fields
    // ------------------------------------------------------------------
    localparam logic [4:0]  FTFTC_REG_TRIM_AMT = 5'h02;
    localparam logic [4:0]  FTFTC_REG_TRIM_EN  = 5'h03;
    localparam logic [4:0]  FTFTC_REG_THR_CFG  = 5'h06;
    localparam logic [4:0]  FTFTC_REG_FLAGS    = 5'h1b;
    localparam int          FTFTC_X_EN_BIT     = 0;
    localparam int          FTFTC_Y_EN_BIT     = 1;
    localparam int          FTFTC_LOW_THR_LSB  = 5;
    localparam int          FTFTC_HIGH_THR_LSB = 2;
    localparam int          FTFTC_HIGH_FLAG_BIT = 7;
    localparam int          FTFTC_LOW_FLAG_BIT  = 6;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  FTFTC_TRIM_AMT_RST = 8'h00;
    localparam logic [1:0]  FTFTC_TRIM_EN_RST  = 2'h0;
    localparam logic [2:0]  FTFTC_LOW_THR_RST  = 3'h0;
    localparam logic [2:0]  FTFTC_HIGH_THR_RST = 3'h7;

    // ------------------------------------------------------------------
    // thresholds in mT, code 7 in the top byte
    // ------------------------------------------------------------------
    localparam logic [63:0] FTFTC_TRIP_TABLE =
        {8'h7e, 8'h70, 8'h62, 8'h54, 8'h46, 8'h38, 8'h29, 8'h1a};
    localparam logic [7:0]  FTFTC_HYST_MT = 8'h06;

endpackage : ftftc_pkg

// ### design/ftftc_top.sv
// field flags, thresholds and bias trim configuration behind a spi slave
`timescale 1ns/10ps
module ftftc_top (
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       SYS_RST,
    // spi link
    input  wire logic       SPI_SCK,
    input  wire logic       SPI_CS_N,
    input  wire logic       SPI_MOSI,
    output logic            SPI_MISO,
    output logic            SPI_MISO_OE,
    // field measurement
    input  wire logic [7:0] FIELD_MT,
    input  wire logic       FIELD_VALID,
    // flag pins
    output logic            LOW_FIELD_FLAG,
    output logic            HIGH_FIELD_FLAG,
    // bias trim to the hall front end
    output logic [7:0]      X_BIAS_REDUCTION,
    output logic [7:0]      Y_BIAS_REDUCTION
);
    import ftftc_pkg::*;

    typedef struct packed {
        logic [2:0]  sck_sync;
        logic [2:0]  cs_sync;
        logic [1:0]  mosi_sync;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0]  bit_cnt;
        logic [7:0]  answer;
        logic        miso;
        logic        miso_oe;
        logic [7:0]  bias_trim_amount;
        logic        x_axis_trim_en;
        logic        y_axis_trim_en;
        logic [2:0]  low_field_threshold;
        logic [2:0]  high_field_threshold;
        logic [7:0]  x_red;
        logic [7:0]  y_red;
    } ftftc_state_t;

    ftftc_state_t state_ff;
    ftftc_state_t nxt_state;
    logic         low_field_flag;
    logic         high_field_flag;
    logic         sck_rise;
    logic         sck_fall;
    logic         cs_fall;
    logic         cs_rise;
    logic         frame_ok;
    logic [2:0]   cmd;
    logic [4:0]   addr;
    logic [7:0]   wdata;
    logic [7:0]   rdata;

    // ------------------------------------------------------------------
    // field comparators
    // ------------------------------------------------------------------
    // separate comparators
    ftftc_field_cmp #(.IS_HIGH(1'b0)) u_low_cmp (
        .clk         (CORE_CLK),
        .rst         (SYS_RST),
        .field_mt    (FIELD_MT),
        .field_valid (FIELD_VALID),
        .thr_code    (state_ff.low_field_threshold),
        .flag        (low_field_flag)
    );

    ftftc_field_cmp #(.IS_HIGH(1'b1)) u_high_cmp (
        .clk         (CORE_CLK),
        .rst         (SYS_RST),
        .field_mt    (FIELD_MT),
        .field_valid (FIELD_VALID),
        .thr_code    (state_ff.high_field_threshold),
        .flag        (high_field_flag)
    );

    // ------------------------------------------------------------------
    // link edge detect and frame decode
    // ------------------------------------------------------------------
    always_comb begin
        sck_rise = state_ff.sck_sync[1] & ~state_ff.sck_sync[2];
        sck_fall = ~state_ff.sck_sync[1] & state_ff.sck_sync[2];
        cs_fall  = ~state_ff.cs_sync[1] & state_ff.cs_sync[2];
        cs_rise  = state_ff.cs_sync[1] & ~state_ff.cs_sync[2];
        frame_ok = (state_ff.bit_cnt == FTFTC_FRAME_CNT);
        cmd      = state_ff.rx[FTFTC_CMD_MSB:FTFTC_CMD_LSB];
        addr     = state_ff.rx[FTFTC_ADDR_MSB:FTFTC_ADDR_LSB];
        wdata    = state_ff.rx[7:0];
    end

    // ------------------------------------------------------------------
    // readback mux
    // ------------------------------------------------------------------
    always_comb begin
        rdata = 8'h00;
        unique case (addr)
            FTFTC_REG_TRIM_AMT: begin
                rdata = state_ff.bias_trim_amount;
            end
            FTFTC_REG_TRIM_EN: begin
                rdata[FTFTC_X_EN_BIT] = state_ff.x_axis_trim_en;
                rdata[FTFTC_Y_EN_BIT] = state_ff.y_axis_trim_en;
            end
            FTFTC_REG_THR_CFG: begin
                rdata[FTFTC_LOW_THR_LSB +: 3]  = state_ff.low_field_threshold;
                rdata[FTFTC_HIGH_THR_LSB +: 3] = state_ff.high_field_threshold;
            end
            FTFTC_REG_FLAGS: begin
                // flags in bits 7 and 6
                rdata[FTFTC_HIGH_FLAG_BIT] = high_field_flag;
                rdata[FTFTC_LOW_FLAG_BIT]  = low_field_flag;
            end
            default: begin
                rdata = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.sck_sync  = {state_ff.sck_sync[1:0], SPI_SCK};
        nxt_state.cs_sync   = {state_ff.cs_sync[1:0], SPI_CS_N};
        nxt_state.mosi_sync = {state_ff.mosi_sync[0], SPI_MOSI};

        if (cs_fall) begin
            nxt_state.bit_cnt = 5'h00;
            // previous read answer goes out now
            nxt_state.tx      = {state_ff.answer, 8'h00};
            nxt_state.miso    = state_ff.answer[7];
            nxt_state.miso_oe = 1'b1;
        end else if (!state_ff.cs_sync[1]) begin
            if (sck_rise) begin
                nxt_state.rx = {state_ff.rx[14:0], state_ff.mosi_sync[1]};
                if (state_ff.bit_cnt != FTFTC_CNT_MAX) begin
                    nxt_state.bit_cnt = state_ff.bit_cnt + 5'h01;
                end
            end
            if (sck_fall && state_ff.bit_cnt != 5'h00) begin
                nxt_state.tx   = {state_ff.tx[14:0], 1'b0};
                nxt_state.miso = state_ff.tx[14];
            end
        end

        if (cs_rise) begin
            nxt_state.miso_oe = 1'b0;
            nxt_state.miso    = 1'b0;
            nxt_state.answer  = 8'h00;
            if (frame_ok && cmd == FTFTC_CMD_READ) begin
                nxt_state.answer = rdata;
            end
            if (frame_ok && cmd == FTFTC_CMD_WRITE) begin
                unique case (addr)
                    FTFTC_REG_TRIM_AMT: begin
                        nxt_state.bias_trim_amount = wdata;
                    end
                    FTFTC_REG_TRIM_EN: begin
                        nxt_state.x_axis_trim_en = wdata[FTFTC_X_EN_BIT];
                        nxt_state.y_axis_trim_en = wdata[FTFTC_Y_EN_BIT];
                    end
                    FTFTC_REG_THR_CFG: begin
                        // low code 7:5, high code 4:2
                        nxt_state.low_field_threshold  = wdata[FTFTC_LOW_THR_LSB +: 3];
                        nxt_state.high_field_threshold = wdata[FTFTC_HIGH_THR_LSB +: 3];
                    end
                    default: begin
                        nxt_state.answer = 8'h00;
                    end
                endcase
            end
        end

        nxt_state.x_red = nxt_state.x_axis_trim_en ? nxt_state.bias_trim_amount : 8'h00;
        nxt_state.y_red = nxt_state.y_axis_trim_en ? nxt_state.bias_trim_amount : 8'h00;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_ff                      <= '0;
            state_ff.sck_sync             <= 3'h0;
            state_ff.cs_sync              <= 3'h7;
            state_ff.bias_trim_amount     <= FTFTC_TRIM_AMT_RST;
            state_ff.x_axis_trim_en       <= FTFTC_TRIM_EN_RST[FTFTC_X_EN_BIT];
            state_ff.y_axis_trim_en       <= FTFTC_TRIM_EN_RST[FTFTC_Y_EN_BIT];
            state_ff.low_field_threshold  <= FTFTC_LOW_THR_RST;
            state_ff.high_field_threshold <= FTFTC_HIGH_THR_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign SPI_MISO         = state_ff.miso;
    assign SPI_MISO_OE      = state_ff.miso_oe;
    assign LOW_FIELD_FLAG   = low_field_flag;
    assign HIGH_FIELD_FLAG  = high_field_flag;
    assign X_BIAS_REDUCTION = state_ff.x_red;
    assign Y_BIAS_REDUCTION = state_ff.y_red;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    property p_reset_trim;
        $fell(SYS_RST) |-> state_ff.bias_trim_amount == 8'h00 && X_BIAS_REDUCTION == 8'h00;
    endproperty
    a_reset_trim: assert property (p_reset_trim) else $error("trim not zero at reset");

    property p_reset_thr;
        $fell(SYS_RST) |-> state_ff.low_field_threshold == 3'h0
            && state_ff.high_field_threshold == 3'h7;
    endproperty
    a_reset_thr: assert property (p_reset_thr) else $error("threshold reset wrong");

    property p_axis_gate;
        !state_ff.x_axis_trim_en && !$past(state_ff.x_axis_trim_en)
            |-> X_BIAS_REDUCTION == 8'h00;
    endproperty
    a_axis_gate: assert property (p_axis_gate) else $error("x trimmed while off");

    property p_both_equal;
        state_ff.x_axis_trim_en && state_ff.y_axis_trim_en ##1 $stable(state_ff)
            |-> X_BIAS_REDUCTION == Y_BIAS_REDUCTION
                && X_BIAS_REDUCTION == state_ff.bias_trim_amount;
    endproperty
    a_both_equal: assert property (p_both_equal) else $error("axes trimmed unequally");

    property p_thr_write;
        cs_rise && frame_ok && cmd == FTFTC_CMD_WRITE && addr == FTFTC_REG_THR_CFG
            |=> state_ff.low_field_threshold == $past(wdata[7:5])
                && state_ff.high_field_threshold == $past(wdata[4:2]);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

    property p_flag_read;
        cs_rise && frame_ok && cmd == FTFTC_CMD_READ && addr == FTFTC_REG_FLAGS
            |=> state_ff.answer == {$past(high_field_flag), $past(low_field_flag), 6'h00};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag answer wrong");

    property p_next_frame;
        cs_fall |=> SPI_MISO_OE && SPI_MISO == $past(state_ff.answer[7]);
    endproperty
    a_next_frame: assert property (p_next_frame) else $error("answer not presented");

    property p_shift_in;
        sck_rise && !state_ff.cs_sync[1] && !cs_fall
            |=> state_ff.rx[0] == $past(state_ff.mosi_sync[1]);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("mosi bit not taken");

    // pins hold their level until a new measurement arrives
    property p_pins;
        !FIELD_VALID |=> $stable(LOW_FIELD_FLAG) && $stable(HIGH_FIELD_FLAG);
    endproperty
    a_pins: assert property (p_pins) else $error("flag pin moved without measurement");

endmodule : ftftc_top

// ### test/ftftc_spi_host.sv
// spi host model that frames reads and writes into the sensor block
`timescale 1ns/10ps
module ftftc_spi_host (
    // bench clock
    input  wire logic clk,
    // spi link
    output logic      sck,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic miso_pin;
    logic oe_seen;

    // pull-down on the data-out pin while the device lets go of it
    assign miso_pin = miso_oe ? miso : 1'b0;

    initial begin
        sck     = 1'b0;
        cs_n    = 1'b1;
        mosi    = 1'b0;
        oe_seen = 1'b0;
    end

    // ------------------------------------------------------------------
    // one frame, half period of four core clocks
    // ------------------------------------------------------------------
    // msb first, select low
    task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
        rx      = 16'h0000;
        oe_seen = 1'b1;
        cs_n    = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[15 - i];
            repeat (4) @(negedge clk);
            oe_seen = oe_seen & miso_oe;
            rx      = {rx[14:0], miso_pin};
            sck     = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // mosi pull-down once released
        mosi = 1'b0;
        repeat (8) @(negedge clk);
    endtask : xfer
endmodule : ftftc_spi_host

// ### test/tb.sv
// self-checking bench for the field flags and trim configuration block
`timescale 1ns/10ps
module tb;
    import ftftc_pkg::*;

    typedef struct packed {
        logic [7:0] delta;
        logic       exp_low;
        logic       exp_high;
    } ftftc_row_t;

    localparam logic [7:0] TRIP_MT [8] =
        '{8'h1a, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7e};
    // field offset from the trip level, then the flags it must leave
    localparam ftftc_row_t ROWS [6] = '{
        '{8'hf9, 1'b1, 1'b0}, '{8'hfa, 1'b1, 1'b0}, '{8'h00, 1'b1, 1'b0},
        '{8'h01, 1'b0, 1'b1}, '{8'hfa, 1'b0, 1'b1}, '{8'hf9, 1'b1, 1'b0}};

    logic        clk;
    logic        rst;
    logic        sck;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic [7:0]  field_mt;
    logic        field_valid;
    logic        low_flag;
    logic        high_flag;
    logic [7:0]  x_red;
    logic [7:0]  y_red;
    logic [15:0] rx;
    logic [7:0]  rdat;
    int          n_fail;
    int          cmp_count;

    ftftc_top dut (
        .CORE_CLK(clk), .SYS_RST(rst), .SPI_SCK(sck), .SPI_CS_N(cs_n),
        .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
        .FIELD_MT(field_mt), .FIELD_VALID(field_valid),
        .LOW_FIELD_FLAG(low_flag), .HIGH_FIELD_FLAG(high_flag),
        .X_BIAS_REDUCTION(x_red), .Y_BIAS_REDUCTION(y_red));

    ftftc_spi_host host (
        .clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

    always #50 clk = ~clk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        host.xfer(16, {FTFTC_CMD_WRITE, addr, data}, rx);
    endtask : wr

    task automatic rd(input logic [4:0] addr, output logic [7:0] data);
        host.xfer(16, {FTFTC_CMD_READ, addr, 8'h00}, rx);
        host.xfer(16, 16'h0000, rx);
        data = rx[15:8];
        check("answer pad", rx[7:0], 8'h00);
    endtask : rd

    task automatic apply_field(input logic [7:0] v);
        field_mt    = v;
        field_valid = 1'b1;
        @(negedge clk);
        field_valid = 1'b0;
        repeat (2) @(negedge clk);
    endtask : apply_field

    task automatic chk_flags(input logic el, input logic eh);
        check("low pin", {7'h00, low_flag}, {7'h00, el});
        check("high pin", {7'h00, high_flag}, {7'h00, eh});
        rd(FTFTC_REG_FLAGS, rdat);
        check("flag status", rdat, {eh, el, 6'h00});
    endtask : chk_flags

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // run limit
    // ------------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("[FAIL] run limit expected end seen hang");
        summarize();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        clk         = 1'b0;
        rst         = 1'b1;
        field_mt    = 8'h00;
        field_valid = 1'b0;
        n_fail      = 0;
        cmp_count   = 0;
        repeat (16) @(negedge clk);
        check("x in reset", x_red, 8'h00);
        check("flags in reset", {6'h00, high_flag, low_flag}, 8'h00);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rd(FTFTC_REG_TRIM_AMT, rdat);
        check("trim amount reset", rdat, 8'h00);
        rd(FTFTC_REG_TRIM_EN, rdat);
        check("enables reset", rdat, 8'h00);
        rd(FTFTC_REG_THR_CFG, rdat);
        check("thresholds reset", rdat, 8'h1c);
        $display("test reset done");

        // ratio two gives 129
        wr(FTFTC_REG_TRIM_AMT, 8'h81);
        for (int en = 0; en < 4; en++) begin
            wr(FTFTC_REG_TRIM_EN, {6'h00, en[1:0]});
            check("x reduction", x_red, en[0] ? 8'h81 : 8'h00);
            check("y reduction", y_red, en[1] ? 8'h81 : 8'h00);
            rd(FTFTC_REG_TRIM_EN, rdat);
            check("enable readback", rdat, {6'h00, en[1:0]});
        end
        wr(FTFTC_REG_TRIM_AMT, 8'hff);
        check("full x reduction", x_red, 8'hff);
        check("full y reduction", y_red, 8'hff);
        rd(FTFTC_REG_TRIM_AMT, rdat);
        check("amount readback", rdat, 8'hff);
        $display("test trim done");

        for (int c = 0; c < 8; c++) begin
            wr(FTFTC_REG_THR_CFG, {c[2:0], c[2:0], 2'b00});
            rd(FTFTC_REG_THR_CFG, rdat);
            check("threshold readback", rdat, {c[2:0], c[2:0], 2'b00});
            foreach (ROWS[r]) begin
                apply_field(TRIP_MT[c] + ROWS[r].delta);
                chk_flags(ROWS[r].exp_low, ROWS[r].exp_high);
            end
        end
        $display("test threshold rows done");

        // low code above high code
        wr(FTFTC_REG_THR_CFG, 8'he0);
        apply_field(8'h64);
        chk_flags(1'b1, 1'b1);
        apply_field(8'h82);
        chk_flags(1'b0, 1'b1);
        $display("test crossed codes done");

        // flags move between the read command and its answer
        host.xfer(16, {FTFTC_CMD_READ, FTFTC_REG_FLAGS, 8'h00}, rx);
        apply_field(8'h0a);
        host.xfer(16, 16'h0000, rx);
        check("captured flags", rx[15:8], 8'h80);
        check("oe in frame", {7'h00, host.oe_seen}, 8'h01);
        check("oe idle", {7'h00, miso_oe}, 8'h00);
        chk_flags(1'b1, 1'b0);
        $display("test capture done");

        host.xfer(15, {FTFTC_CMD_WRITE, FTFTC_REG_TRIM_AMT, 8'h55}, rx);
        host.xfer(16, {3'h7, FTFTC_REG_TRIM_AMT, 8'h55}, rx);
        rd(FTFTC_REG_TRIM_AMT, rdat);
        check("refused writes", rdat, 8'hff);
        wr(FTFTC_REG_FLAGS, 8'h3f);
        chk_flags(1'b1, 1'b0);
        rd(5'h09, rdat);
        check("unmapped read", rdat, 8'h00);
        $display("test refusals done");

        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        check("x after reset", x_red, 8'h00);
        rd(FTFTC_REG_THR_CFG, rdat);
        check("thresholds after reset", rdat, 8'h1c);
        $display("test second reset done");
        summarize();
    end
endmodule : tb
